// >>> src/gpio_port_config.sv
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "gpio_port_params.svh"
// Function
// - output pin reads back output latch
// - input pin reads back sampled pin level
// - ports C,D: float, pull-up, open-drain, push-pull
// - port B option enables floating/pull-up interrupt
// - port F: bit2 floating irq, 1:0 pull-up irq
// - port E general bits use standard coding
// - wait keeps pins; port interrupt exits wait
// - halt keeps pins; port interrupt exits halt
// - interrupt needs irq config and clear mask
// - all port registers reset to zero
module gpio_port_config #(
  parameter int NUM_PORTS = 5,
  parameter logic FLASH_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [39:0] pin_in,
  output logic [39:0] pad_out,
  output logic [39:0] pad_oe_n,
  output logic [39:0] pullup_en,
  output logic irq,
  output logic wakeup,
  output logic [1:0] pwr_state
);
  if (NUM_PORTS != 5) begin : g_bad_ports
    $error("gpio_port_config serves exactly five ports");
  end

  localparam logic [7:0] INONLY_E = FLASH_VARIANT ? (8'h01 << `PORT_E_BIT_TWO) : 8'h00;
  // without the flash pad, port e bit two is a normal pin that never pulls up as an input
  localparam logic [7:0] FLOAT_E = FLASH_VARIANT ? 8'h00 : (8'h01 << `PORT_E_BIT_TWO);
  localparam logic [39:0] IRQ_MASKS = {`PORT_F_FLOAT_IRQ | `PORT_F_PULLUP_IRQ, 8'h00, 8'h00, 8'h00,
                                       `PORT_B_FLOAT_IRQ | `PORT_B_PULLUP_IRQ};
  localparam logic [39:0] FLOAT_MASKS = {`PORT_F_FLOAT_IRQ, FLOAT_E, 8'h00, 8'h00, `PORT_B_FLOAT_IRQ};
  localparam logic [39:0] INONLY_MASKS = {8'h00, INONLY_E, 8'h00, 8'h00, 8'h00};

  logic [39:0] data_r, data_nxt;
  logic [39:0] dir_r, dir_nxt;
  logic [39:0] opt_r, opt_nxt;
  logic [39:0] stat_r, stat_nxt;
  logic [39:0] mask_r, mask_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  gpio_port_pkg::pwr_state_t pwr_r, pwr_nxt;
  logic [39:0] read_val, ev, pad_out_c, pad_oe_n_c, pullup_c;
  logic [39:0] pin_q_r;
  logic [39:0] pad_out_r, pad_oe_n_r, pullup_r;
  logic irq_r, irq_nxt, wake_r, wake_nxt;

  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, ar_r, ar_nxt, rv_r, rv_nxt;
  logic awrdy_r, wrdy_r, arrdy_r;
  logic [7:0] awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_port
      gpio_port #(
        .IRQ_MASK(IRQ_MASKS[p*8 +: 8]),
        .FLOAT_MASK(FLOAT_MASKS[p*8 +: 8]),
        .INONLY_MASK(INONLY_MASKS[p*8 +: 8])
      ) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .dir(dir_r[p*8 +: 8]),
        .opt(opt_r[p*8 +: 8]),
        .latch(data_r[p*8 +: 8]),
        .pin_in(pin_q_r[p*8 +: 8]),
        .pad_out(pad_out_c[p*8 +: 8]),
        .pad_oe_n(pad_oe_n_c[p*8 +: 8]),
        .pullup_en(pullup_c[p*8 +: 8]),
        .read_val(read_val[p*8 +: 8]),
        .event_pulse(ev[p*8 +: 8])
      );
    end
  endgenerate

  // register write/read decode
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge8 = st[0] ? wd[7:0] : old;
  endfunction

  logic wr_fire, rd_fire;
  logic [7:0] rd_off;
  logic [2:0] wr_port, rd_port;
  logic [7:0] wr_off;
  logic [39:0] stat_clr;

  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    bv_nxt = bv_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    ar_nxt = ar_r;
    rv_nxt = rv_r;
    araddr_nxt = araddr_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    data_nxt = data_r;
    dir_nxt = dir_r;
    opt_nxt = opt_r;
    mask_nxt = mask_r;
    ctrl_nxt = ctrl_r;
    stat_clr = 40'h00_0000_0000;
    wr_port = 3'h0;
    wr_off = 8'h00;
    rd_off = 8'h00;
    rd_port = 3'h0;
    if (s_axi_awvalid && !aw_r) begin
      aw_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r) begin
      w_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    wr_fire = aw_r && w_r && !bv_r;
    if (wr_fire) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      bresp_nxt = `AXI_OKAY;
      if (awaddr_r < `IRQ_STATUS_OFF && awaddr_r[1:0] == 2'h0) begin
        wr_port = 3'((awaddr_r >> 2) / 8'd3);
        wr_off = awaddr_r - 8'(wr_port) * `PORT_STRIDE;
        case (wr_off)
          `PORT_DATA_OFF: data_nxt[wr_port*8 +: 8] = merge8(data_r[wr_port*8 +: 8], wdata_r, wstrb_r);
          `PORT_DIR_OFF: dir_nxt[wr_port*8 +: 8] = merge8(dir_r[wr_port*8 +: 8], wdata_r, wstrb_r);
          `PORT_OPT_OFF: opt_nxt[wr_port*8 +: 8] = merge8(opt_r[wr_port*8 +: 8], wdata_r, wstrb_r);
          default: bresp_nxt = `AXI_SLVERR;
        endcase
      end else if (awaddr_r == `IRQ_MASK_OFF) begin
        for (int k = 0; k < 4; k++) begin
          if (wstrb_r[k]) mask_nxt[k*8 +: 8] = wdata_r[k*8 +: 8];
        end
        if (wstrb_r[3]) mask_nxt[39:32] = wdata_r[31:24];
        if (wstrb_r[0]) mask_nxt[39:32] = 8'h00;
      end else if (awaddr_r == `CTRL_OFF) begin
        if (wstrb_r[0]) ctrl_nxt = wdata_r[2:0];
      end else if (awaddr_r != `IRQ_STATUS_OFF) begin
        bresp_nxt = `AXI_SLVERR;
      end
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_arvalid && !ar_r) begin
      ar_nxt = 1'b1;
      araddr_nxt = s_axi_araddr;
    end
    rd_fire = ar_r && !rv_r;
    if (rd_fire) begin
      ar_nxt = 1'b0;
      rv_nxt = 1'b1;
      rresp_nxt = `AXI_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (araddr_r < `IRQ_STATUS_OFF && araddr_r[1:0] == 2'h0) begin
        rd_port = 3'((araddr_r >> 2) / 8'd3);
        rd_off = araddr_r - 8'(rd_port) * `PORT_STRIDE;
        case (rd_off)
          `PORT_DATA_OFF: rdata_nxt[7:0] = read_val[rd_port*8 +: 8];
          `PORT_DIR_OFF: rdata_nxt[7:0] = dir_r[rd_port*8 +: 8];
          `PORT_OPT_OFF: rdata_nxt[7:0] = opt_r[rd_port*8 +: 8];
          default: rresp_nxt = `AXI_SLVERR;
        endcase
      end else if (araddr_r == `IRQ_STATUS_OFF) begin
        rdata_nxt = stat_r[31:0];
        stat_clr = stat_r;
      end else if (araddr_r == `IRQ_MASK_OFF) begin
        rdata_nxt = mask_r[31:0];
      end else if (araddr_r == `CTRL_OFF) begin
        rdata_nxt = {27'h000_0000, pwr_r, ctrl_r};
      end else begin
        rresp_nxt = `AXI_SLVERR;
      end
    end
    if (rv_r && s_axi_rready) rv_nxt = 1'b0;
    // set wins over the read clear
    stat_nxt = (stat_r & ~stat_clr) | ev;
    irq_nxt = |(stat_nxt & mask_nxt) & ~ctrl_nxt[`CTRL_GLOBAL_MASK_BIT];
    wake_nxt = |(ev & mask_r);
  end

  // power state: pad controls are untouched by low power modes
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      gpio_port_pkg::PWR_RUN: begin
        if (ctrl_nxt[`CTRL_HALT_BIT]) pwr_nxt = gpio_port_pkg::PWR_HALT;
        else if (ctrl_nxt[`CTRL_WAIT_BIT]) pwr_nxt = gpio_port_pkg::PWR_WAIT;
      end
      gpio_port_pkg::PWR_WAIT: if (wake_nxt) pwr_nxt = gpio_port_pkg::PWR_RUN;
      gpio_port_pkg::PWR_HALT: if (wake_nxt) pwr_nxt = gpio_port_pkg::PWR_RUN;
      default: pwr_nxt = gpio_port_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= {5{`PORT_RESET_VAL}};
      dir_r <= {5{`PORT_RESET_VAL}};
      opt_r <= {5{`PORT_RESET_VAL}};
      stat_r <= 40'h00_0000_0000;
      mask_r <= 40'h00_0000_0000;
      ctrl_r <= 3'h0;
      pwr_r <= gpio_port_pkg::PWR_RUN;
      // idle pin level, so the edge detector sees no step at release
      pin_q_r <= 40'hFF_FFFF_FFFF;
      pad_out_r <= 40'h00_0000_0000;
      pad_oe_n_r <= 40'hFF_FFFF_FFFF;
      pullup_r <= 40'h00_0000_0000;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      ar_r <= 1'b0;
      rv_r <= 1'b0;
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
      arrdy_r <= 1'b1;
      awaddr_r <= 8'h00;
      araddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      bresp_r <= 2'h0;
      rresp_r <= 2'h0;
    end else begin
      data_r <= data_nxt;
      dir_r <= dir_nxt;
      opt_r <= opt_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      // wait/halt requests are one-shot
      ctrl_r <= ctrl_nxt & 3'h1;
      pwr_r <= pwr_nxt;
      pin_q_r <= pin_in;
      pad_out_r <= pad_out_c;
      pad_oe_n_r <= pad_oe_n_c;
      pullup_r <= pullup_c;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      ar_r <= ar_nxt;
      rv_r <= rv_nxt;
      awrdy_r <= ~aw_nxt;
      wrdy_r <= ~w_nxt;
      arrdy_r <= ~ar_nxt;
      awaddr_r <= awaddr_nxt;
      araddr_r <= araddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      rdata_r <= rdata_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = wrdy_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pad_out = pad_out_r;
  assign pad_oe_n = pad_oe_n_r;
  assign pullup_en = pullup_r;
  assign irq = irq_r;
  assign wakeup = wake_r;
  assign pwr_state = pwr_r;
endmodule // gpio_port_config

// >>> src/gpio_port_params.svh
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH
// register byte offsets, one port per group of three words
`define PORT_DATA_OFF 8'h00
`define PORT_DIR_OFF 8'h04
`define PORT_OPT_OFF 8'h08
`define PORT_STRIDE 8'h0C
`define IRQ_STATUS_OFF 8'h3C
`define IRQ_MASK_OFF 8'h40
`define CTRL_OFF 8'h44
`define PORT_RESET_VAL 8'h00
`define PORT_B_FLOAT_IRQ 8'h88
`define PORT_B_PULLUP_IRQ 8'h77
`define PORT_F_FLOAT_IRQ 8'h04
`define PORT_F_PULLUP_IRQ 8'h03
`define PORT_E_BIT_TWO 2
`define CTRL_GLOBAL_MASK_BIT 0
`define CTRL_WAIT_BIT 1
`define CTRL_HALT_BIT 2
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// >>> src/gpio_port_pkg.sv
package gpio_port_pkg;
  typedef enum logic [2:0] {
    PORT_B,
    PORT_C,
    PORT_D,
    PORT_E,
    PORT_F
  } port_id_t;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_WAIT,
    PWR_HALT
  } pwr_state_t;
endpackage

// >>> src/gpio_pin_cell.sv
`include "gpio_port_params.svh"
// one pin: direction/option decode into pad controls and interrupt enable
module gpio_pin_cell #(
  parameter logic IRQ_CAPABLE = 1'b0,
  parameter logic IRQ_FLOATING = 1'b0,
  parameter logic INPUT_ONLY_PULLUP = 1'b0
) (
  input wire logic dir,
  input wire logic opt,
  input wire logic latch,
  input wire logic pin_in,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pullup_en,
  output logic irq_en,
  output logic read_bit
);
  logic is_out;
  always_comb begin
    is_out = dir & ~INPUT_ONLY_PULLUP;
    pad_out = latch;
    // push-pull drives both levels, open-drain only pulls low
    pad_oe_n = ~(is_out & (opt | ~latch));
    pullup_en = INPUT_ONLY_PULLUP | (~is_out & opt & ~IRQ_FLOATING);
    irq_en = IRQ_CAPABLE & ~is_out & opt;
    read_bit = is_out ? latch : pin_in;
  end
endmodule // gpio_pin_cell

// >>> src/gpio_port.sv
`include "gpio_port_params.svh"
// one 8-bit port: pin cells, input event detection
module gpio_port #(
  parameter logic [7:0] IRQ_MASK = 8'h00,
  parameter logic [7:0] FLOAT_MASK = 8'h00,
  parameter logic [7:0] INONLY_MASK = 8'h00
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] dir,
  input wire logic [7:0] opt,
  input wire logic [7:0] latch,
  input wire logic [7:0] pin_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n,
  output logic [7:0] pullup_en,
  output logic [7:0] read_val,
  output logic [7:0] event_pulse
);
  logic [7:0] irq_en;
  logic [7:0] prev_r;
  logic [7:0] prev_nxt;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      gpio_pin_cell #(
        .IRQ_CAPABLE(IRQ_MASK[i]),
        .IRQ_FLOATING(FLOAT_MASK[i]),
        .INPUT_ONLY_PULLUP(INONLY_MASK[i])
      ) u_cell (
        .dir(dir[i]),
        .opt(opt[i]),
        .latch(latch[i]),
        .pin_in(pin_in[i]),
        .pad_out(pad_out[i]),
        .pad_oe_n(pad_oe_n[i]),
        .pullup_en(pullup_en[i]),
        .irq_en(irq_en[i]),
        .read_bit(read_val[i])
      );
    end
  endgenerate
  always_comb begin
    prev_nxt = pin_in;
    // falling edge on an interrupt-configured input is the event
    event_pulse = irq_en & prev_r & ~pin_in;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= 8'hFF;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule // gpio_port

// >>> dv/gpio_port_config_sva.sv
module gpio_port_config_chk #(
  parameter logic FLASH_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe_n,
  input wire logic [39:0] pullup_en,
  input wire logic irq,
  input wire logic wakeup,
  input wire logic [1:0] pwr_state
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property ($rose(aresetn) |-> &pad_oe_n && pullup_en == 40'h0 && !irq)
    else $error("outputs not at reset state");
  pull_drive_a: assert property ((~pad_oe_n & pullup_en) == 40'h0)
    else $error("pull-up on while driving");
  e2_input_a: assert property (FLASH_VARIANT && $past(aresetn, 3) |-> pad_oe_n[26] && pullup_en[26])
    else $error("port e bit two not input pull-up");
  wake_run_a: assert property (wakeup |-> ##[0:2] pwr_state == 2'h0)
    else $error("wakeup did not restore run");
  pins_hold_a: assert property (pwr_state != 2'h0 && $past(pwr_state) != 2'h0 |->
    $stable(pad_oe_n) && $stable(pad_out) && $stable(pullup_en))
    else $error("pins moved in low power");
  pwr_legal_a: assert property (pwr_state != 2'h3)
    else $error("illegal power state");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule // gpio_port_config_chk

bind gpio_port_config gpio_port_config_chk #(.FLASH_VARIANT(FLASH_VARIANT)) chk (.*);

// >>> dv/pin_board.sv
module pin_board (
  input wire logic aclk,
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe_n,
  input wire logic [39:0] pullup_en,
  input wire logic [39:0] drv_en,
  input wire logic [39:0] drv_val,
  output logic [39:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] float_r = 40'h00_0000_0000;
  // an undriven, unpulled pin wanders every cycle
  always @(posedge aclk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (drv_en[i])
        pin_in[i] = drv_val[i];
      else if (!pad_oe_n[i])
        pin_in[i] = pad_out[i];
      else if (pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = float_r[i];
    end
  end
endmodule // pin_board

// >>> dv/tb_gpio_port_config.sv
module tb_gpio_port_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wakeup;
  logic [1:0] s_axi_bresp, s_axi_rresp, pwr_state;
  logic [39:0] pin_in, pad_out, pad_oe_n, pullup_en;
  logic [39:0] drv_en = {40{1'b1}}, drv_val = {5{8'h3D}};
  int failures = 0, check_count = 0, cyc = 0;
  gpio_port_config dut (.*);
  pin_board board (.aclk(aclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
    .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    bit b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        b = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        b = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    for (int a = 0; a < 60; a += 4) begin
      rd(8'(a), d, r);
      chk(d, (a % 12 == 0) ? 32'h3D : 32'h0, "reset read");
    end
  endtask
  task automatic t_cfg();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] oe_exp [5] = '{8'hA0, 8'hA0, 8'hA0, 8'hA4, 8'hA0};
    logic [7:0] pu_exp [5] = '{8'h77, 8'hFF, 8'hFF, 8'hFF, 8'hFB};
    for (int p = 0; p < 5; p++) begin
      drv_en[p*8 +: 8] <= 8'h00;
      wr(8'(12*p), 8'hA5, r);
      wr(8'(12*p+4), 8'hFF, r);
      wr(8'(12*p+8), 8'h0F, r);
      repeat (3) @(posedge aclk);
      chk(pad_oe_n[p*8 +: 8], oe_exp[p], "out enable");
      chk(pad_out[p*8 +: 4] | 4'h4, 4'h5, "out level");
      chk(pullup_en[p*8 +: 8], (p == 3) ? 8'h04 : 8'h00, "out pull");
      rd(8'(12*p), d, r);
      chk(d, 32'hA5, "out read");
      drv_en[p*8 +: 8] <= 8'hFF;
      wr(8'(12*p+4), 8'h00, r);
      wr(8'(12*p+8), 8'hFF, r);
      repeat (3) @(posedge aclk);
      chk(pullup_en[p*8 +: 8], pu_exp[p], "in pull");
      chk(pad_oe_n[p*8 +: 8], 8'hFF, "in enable");
      rd(8'(12*p), d, r);
      chk(d, 32'h3D, "in read");
    end
  endtask
  task automatic t_irq();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h40, 8'h01, r);
    wr(8'h44, 8'h01, r);
    rd(8'h3C, d, r);
    drv_val[0] <= 1'b0;
    repeat (5) @(posedge aclk);
    chk(irq, 1'b0, "irq global mask");
    wr(8'h44, 8'h00, r);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1, "irq raise");
    rd(8'h3C, d, r);
    chk(d[0], 1'b1, "status");
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0, "irq clear");
    drv_val[1:0] <= 2'b01;
    repeat (5) @(posedge aclk);
    chk(irq, 1'b0, "irq masked bit");
    drv_val[1:0] <= 2'b11;
    rd(8'h3C, d, r);
    drv_val[8] <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(8'h3C, d, r);
    chk(d[15:8], 8'h00, "no irq config");
    drv_val[8] <= 1'b1;
  endtask
  task automatic t_pwr();
    logic [31:0] d;
    logic [1:0] r;
    logic [39:0] oe;
    int n;
    for (int m = 1; m < 3; m++) begin
      rd(8'h3C, d, r);
      wr(8'h44, 8'(2*m), r);
      repeat (2) @(posedge aclk);
      chk(pwr_state, m, "low power");
      oe = pad_oe_n;
      drv_val[0] <= 1'b0;
      n = 0;
      while (!wakeup && n < 50) begin
        @(posedge aclk);
        n++;
      end
      repeat (3) @(posedge aclk);
      chk(pwr_state, 2'h0, "woken");
      chk(pad_oe_n, oe, "pins kept");
      drv_val[0] <= 1'b1;
    end
  endtask
  task automatic t_err();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h48, d, r);
    chk(r, 2'h2, "unmapped read");
    wr(8'hFC, 8'h00, r);
    chk(r, 2'h2, "unmapped write");
    rd(8'h01, d, r);
    chk(r, 2'h2, "unaligned read");
    wr(8'h3C, 8'hFF, r);
    chk(r, 2'h0, "status write");
    rd(8'h40, d, r);
    chk(d, 32'h01, "mask read");
    rd(8'h44, d, r);
    chk(d, 32'h00, "ctrl read");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_cfg();
    t_irq();
    t_pwr();
    t_err();
    summarize();
  end
endmodule // tb_gpio_port_config
